// file: bench/eac_cpu_model.sv
// Purpose: Behavioural processor software driving the I/O register port.
// Assumes: Inputs change just after a rising edge, one write per two cycles, one read per three.
// Notes:   Released data lines carry inverted junk, never the old value.
module eac_cpu_model (
    input  wire logic       clk_sys,
    input  wire logic [7:0] io_rdata,
    output logic      [1:0] io_sel,
    output logic            io_wr,
    output logic            io_rd,
    output logic      [7:0] io_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // The bus is idle at time zero.
    initial begin
        io_sel   = 2'h0;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        io_wdata = 8'h00;
    end

    // One register write, held until the edge that takes it.
    task automatic wr(input logic [1:0] s, input logic [7:0] d);
        @(posedge clk_sys);
        io_sel   <= s;
        io_wdata <= d;
        io_wr    <= 1'b1;
        @(posedge clk_sys);
        io_wr    <= 1'b0;
        io_wdata <= ~d;
    endtask : wr

    // One register read; the answer is registered at the taking edge and sampled one cycle later.
    task automatic rd(input logic [1:0] s, output logic [7:0] d);
        @(posedge clk_sys);
        io_sel <= s;
        io_rd  <= 1'b1;
        @(posedge clk_sys);
        io_rd  <= 1'b0;
        @(posedge clk_sys);
        #1 d = io_rdata;
    endtask : rd

    // Software write: poll the strobe, load operands, arm, then strobe at once.
    task automatic ee_write(input logic [8:0] a, input logic [7:0] d);
        logic [7:0] c;
        c = 8'h02;
        for (int i = 0; i < 2000 && c[1] !== 1'b0; i++) rd(eac_pkg::SEL_CONTROL, c);
        wr(eac_pkg::SEL_ADDR_HI, {7'h00, a[8]});
        wr(eac_pkg::SEL_ADDR_LO, a[7:0]);
        wr(eac_pkg::SEL_DATA, d);
        wr(eac_pkg::SEL_CONTROL, 8'h0C);
        wr(eac_pkg::SEL_CONTROL, 8'h0A);
    endtask : ee_write
endmodule : eac_cpu_model

// file: bench/eac_monitor.sv
// Purpose: Port-level checks of the EEPROM access control block.
// Assumes: One clock domain; sys_rst is synchronous and active high.
// Notes:   Write length is counted in clk_sys cycles, one hundred per oscillator tick.
module eac_monitor #(
    parameter logic [eac_pkg::WRITE_CNT_W-1:0] WRITE_OSC_CYCLES = 14'(eac_pkg::WRITE_OSC_CYCLES)
) (
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    input wire logic       cpu_rst,
    input wire logic [1:0] io_sel,
    input wire logic       io_wr,
    input wire logic       io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic       global_irq_enable,
    input wire logic       self_prog_active,
    input wire logic       ready_irq,
    input wire logic       cpu_stall,
    input wire logic       osc_run_req
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LEN = int'(WRITE_OSC_CYCLES) * eac_pkg::OSC_DIV;  // Write span in clocks.
    logic [23:0] run_cnt;                                              // Cycles of this write.
    wire logic   ctrl_wr = io_wr && (io_sel == eac_pkg::SEL_CONTROL); // Control write taken.

    // Counts busy cycles; cleared when idle so each write is measured alone.
    always_ff @(posedge clk_sys) begin
        run_cnt <= (sys_rst || !osc_run_req) ? 24'h00_0000 : run_cnt + 24'h00_0001;
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_irq_gate; ready_irq |-> global_irq_enable; endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("ready irq without global enable");
    property p_irq_busy; osc_run_req |-> !ready_irq; endproperty
    a_irq_busy: assert property (p_irq_busy) else $error("ready irq during a write");
    property p_start_cause; $rose(osc_run_req) |-> $past(ctrl_wr && io_wdata[1]); endproperty
    a_start_cause: assert property (p_start_cause) else $error("write began unasked");
    property p_wr_stall; $rose(osc_run_req) |-> cpu_stall[*2] ##1 !cpu_stall; endproperty
    a_wr_stall: assert property (p_wr_stall) else $error("write stall not two cycles");
    property p_sp_block;
        ctrl_wr && io_wdata[1] && self_prog_active && !osc_run_req |=> !osc_run_req;
    endproperty
    a_sp_block: assert property (p_sp_block) else $error("write began during flash busy");
    property p_rd_stall;
        ctrl_wr && io_wdata[0] && !io_wdata[1] && !osc_run_req && !cpu_stall
            |=> cpu_stall[*4] ##1 !cpu_stall;
    endproperty
    a_rd_stall: assert property (p_rd_stall) else $error("read stall not four cycles");
    property p_rd_refused; ctrl_wr && io_wdata[0] && osc_run_req && !cpu_stall |=> !cpu_stall;
    endproperty
    a_rd_refused: assert property (p_rd_refused) else $error("read accepted while busy");
    property p_len; $fell(osc_run_req) |-> run_cnt >= LEN && run_cnt <= LEN + 1; endproperty
    a_len: assert property (p_len) else $error("write length wrong");
    property p_rdata_hold; !$past(io_rd) |-> $stable(io_rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved unasked");
endmodule : eac_monitor

bind eac_top eac_monitor #(.WRITE_OSC_CYCLES(WRITE_OSC_CYCLES)) eac_monitor_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .cpu_rst(cpu_rst), .io_sel(io_sel),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .global_irq_enable(global_irq_enable), .self_prog_active(self_prog_active),
    .ready_irq(ready_irq), .cpu_stall(cpu_stall), .osc_run_req(osc_run_req)
);

// file: bench/tb_top.sv
// Purpose: Self-checking bench for the EEPROM access control block.
// Assumes: A short write of four oscillator ticks, four hundred clocks.
// Notes:   Register rows run first; interlocks and resets follow by hand.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [13:0] N_OSC = 14'h0004;  // Shortened write for run time.
    typedef struct packed {
        logic [1:0] sel;
        logic [7:0] wd;
        logic [7:0] exp;
    } eac_row_t;
    eac_row_t   rows [5] = '{'{2'h0, 8'hF0, 8'h00}, '{2'h2, 8'hA5, 8'hA5},
        '{2'h3, 8'hFF, 8'h01}, '{2'h1, 8'h3C, 8'h3C}, '{2'h0, 8'hF8, 8'h08}};
    logic       clk_sys           = 1'b0;
    logic       sys_rst           = 1'b1;
    logic       cpu_rst           = 1'b0;
    logic       global_irq_enable = 1'b0;
    logic       self_prog_active  = 1'b0;
    logic [1:0] io_sel;
    logic       io_wr, io_rd, ready_irq, cpu_stall, osc_run_req;
    logic [7:0] io_wdata, io_rdata, d;
    int         bad_count         = 0;
    int         compares          = 0;
    longint     t0;

    eac_top #(.WRITE_OSC_CYCLES(N_OSC)) eac_top_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .cpu_rst(cpu_rst), .io_sel(io_sel),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .global_irq_enable(global_irq_enable), .self_prog_active(self_prog_active),
        .ready_irq(ready_irq), .cpu_stall(cpu_stall), .osc_run_req(osc_run_req));
    eac_cpu_model eac_cpu_model_inst (.clk_sys(clk_sys), .io_rdata(io_rdata),
        .io_sel(io_sel), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata));

    always #5 clk_sys = ~clk_sys;

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    // Waits for the write engine to go idle, bounded well beyond one write.
    task automatic wait_idle();
        #1;
        for (int i = 0; i < 1000 && osc_run_req !== 1'b0; i++) begin
            @(posedge clk_sys);
            #1;
        end
        check({7'h00, osc_run_req}, 8'h00);
    endtask : wait_idle

    // Sets the address and reads one byte through the data register.
    task automatic ee_read(input logic [8:0] a, output logic [7:0] q);
        eac_cpu_model_inst.wr(eac_pkg::SEL_ADDR_HI, {7'h00, a[8]});
        eac_cpu_model_inst.wr(eac_pkg::SEL_ADDR_LO, a[7:0]);
        eac_cpu_model_inst.wr(eac_pkg::SEL_CONTROL, 8'h01);
        eac_cpu_model_inst.rd(eac_pkg::SEL_DATA, q);
    endtask : ee_read

    // A hang counts as a mismatch and ends the run the usual way.
    initial begin
        repeat (30000) @(posedge clk_sys);
        bad_count++;
        results();
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        foreach (rows[i]) begin
            eac_cpu_model_inst.wr(rows[i].sel, rows[i].wd);
            eac_cpu_model_inst.rd(rows[i].sel, d);
            check(d, rows[i].exp);
        end
        @(posedge clk_sys);
        global_irq_enable <= 1'b1;
        @(posedge clk_sys);
        #1 check({7'h00, ready_irq}, 8'h01);
        $display("register test done");
        // Armed write to 0x1A5; operands changed while busy must not leak in.
        eac_cpu_model_inst.wr(eac_pkg::SEL_CONTROL, 8'h0C);
        eac_cpu_model_inst.wr(eac_pkg::SEL_CONTROL, 8'h0A);
        #1 check({5'h00, ready_irq, cpu_stall, osc_run_req}, 8'h03);
        t0 = $time;
        eac_cpu_model_inst.wr(eac_pkg::SEL_ADDR_LO, 8'h00);
        eac_cpu_model_inst.wr(eac_pkg::SEL_DATA, 8'h77);
        eac_cpu_model_inst.wr(eac_pkg::SEL_CONTROL, 8'h09);
        eac_cpu_model_inst.rd(eac_pkg::SEL_ADDR_LO, d);
        check(d, 8'hA5);
        eac_cpu_model_inst.rd(eac_pkg::SEL_CONTROL, d);
        check(d, 8'h0A);
        @(posedge clk_sys);
        cpu_rst <= 1'b1;
        @(posedge clk_sys);
        cpu_rst <= 1'b0;
        #1 check({7'h00, osc_run_req}, 8'h01);
        wait_idle();
        check({7'h00, ($time - t0) / 10 inside {[400:401]}}, 8'h01);
        eac_cpu_model_inst.rd(eac_pkg::SEL_CONTROL, d);
        check(d, 8'h00);
        ee_read(9'h1A5, d);
        check(d, 8'h3C);
        $display("write test done");
        // Strobe unarmed, arm and strobe together, strobe too late, flash busy.
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            self_prog_active <= (k == 3);
            if (k >= 2) eac_cpu_model_inst.wr(eac_pkg::SEL_CONTROL, 8'h04);
            if (k == 2) repeat (3) @(posedge clk_sys);
            eac_cpu_model_inst.wr(eac_pkg::SEL_CONTROL, (k == 1) ? 8'h06 : 8'h02);
            #1 check({6'h00, cpu_stall, osc_run_req}, 8'h00);
            repeat (6) @(posedge clk_sys);
        end
        self_prog_active <= 1'b0;
        $display("refusal test done");
        // Back-to-back software writes; the second polls the first to its end.
        // Global interrupts stay masked through both sequences.
        @(posedge clk_sys);
        global_irq_enable <= 1'b0;
        eac_cpu_model_inst.ee_write(9'h000, 8'h5A);
        eac_cpu_model_inst.ee_write(9'h1FF, 8'hC3);
        wait_idle();
        check({7'h00, ready_irq}, 8'h00);
        @(posedge clk_sys);
        global_irq_enable <= 1'b1;
        @(posedge clk_sys);
        #1 check({7'h00, ready_irq}, 8'h01);
        ee_read(9'h000, d);
        check(d, 8'h5A);
        ee_read(9'h1FF, d);
        check(d, 8'hC3);
        $display("back to back test done");
        results();
    end
endmodule : tb_top

// file: hdl/eac_top.sv
// Purpose: Access control for the 512-byte data EEPROM as seen by the processor.
// Assumes: I/O port writes and reads are single-cycle strobes in clk_sys.
// Notes:   cpu_rst clears software state but lets a running write finish.
module eac_top #(
    parameter logic [eac_pkg::WRITE_CNT_W-1:0] WRITE_OSC_CYCLES =
        14'(eac_pkg::WRITE_OSC_CYCLES)
) (
    input  wire logic                         clk_sys,
    input  wire logic                         sys_rst,
    input  wire logic                         cpu_rst,
    input  wire logic [1:0]                   io_sel,
    input  wire logic                         io_wr,
    input  wire logic                         io_rd,
    input  wire logic [eac_pkg::DATA_W-1:0]   io_wdata,
    output logic      [eac_pkg::DATA_W-1:0]   io_rdata,
    input  wire logic                         global_irq_enable,
    input  wire logic                         self_prog_active,
    output logic                              ready_irq,
    output logic                              cpu_stall,
    output logic                              osc_run_req
);

    // Software-visible register state.
    logic                          ready_irq_enable; // Interrupt enable bit.
    logic                          master_write_arm; // Arm bit, self-clearing.
    logic [1:0]                    arm_cnt;          // Cycles left in the arm window.
    logic                          write_strobe;     // High for a whole write.
    logic                          read_strobe;      // High for one cycle after a read.
    logic [eac_pkg::ADDR_W-1:0]    byte_address_reg; // Selected byte.
    logic [eac_pkg::DATA_W-1:0]    byte_data_reg;    // Byte to write or byte read.
    logic [2:0]                    stall_cnt;        // Processor stall cycles left.

    // Latched write operands; software may change its registers mid-write.
    // Both are cleared only by power-on reset, never by the processor reset.
    logic [eac_pkg::ADDR_W-1:0]    wr_addr;
    logic [eac_pkg::DATA_W-1:0]    wr_data;

    // Storage array; it keeps its contents through every reset.
    // Its contents are unknown in simulation until a byte is written.
    logic [eac_pkg::DATA_W-1:0]    mem [eac_pkg::MEM_BYTES];

    // Start, busy and done travel to the write timer in one bundle.
    // The controller raises start; the timer answers with busy and done.
    eac_timer_if tmr ();

    // Decoded write strobes for each register.
    // Only one select code is live per access, so at most one of these is high.
    wire wr_ctrl   = io_wr && (io_sel == eac_pkg::SEL_CONTROL);
    wire wr_data_s = io_wr && (io_sel == eac_pkg::SEL_DATA);
    wire wr_alo    = io_wr && (io_sel == eac_pkg::SEL_ADDR_LO);
    wire wr_ahi    = io_wr && (io_sel == eac_pkg::SEL_ADDR_HI);

    // Fields of a control register write.
    // The arm and strobe bits act separately; a strobe written with the arm bit finds the arm still clear.
    wire set_arm    = wr_ctrl && io_wdata[eac_pkg::BIT_ARM];
    wire set_strobe = wr_ctrl && io_wdata[eac_pkg::BIT_WRITE_STROBE];
    wire set_read   = wr_ctrl && io_wdata[eac_pkg::BIT_READ_STROBE];

    // A write starts only when armed, idle and flash self-programming is quiet.
    wire write_busy  = write_strobe || tmr.busy;
    wire write_start = set_strobe && master_write_arm
                       && !write_busy
                       && !self_prog_active;
    // A strobe that arrives while busy is dropped rather than queued.
    // Software polls the strobe bit before each write, and a queued write
    // would hide from that poll.
    // Reads and address changes are locked out while a write runs.
    wire read_start  = set_read && !write_busy;
    wire addr_open   = !write_busy;

    assign tmr.start = write_start;

    // Interrupt level, not a pulse: it stands as long as the strobe is low.
    assign ready_irq   = ready_irq_enable && global_irq_enable && !write_strobe;
    assign cpu_stall   = (stall_cnt != 3'h0);
    // The oscillator must keep running while a write is active, even in sleep.
    assign osc_run_req = tmr.busy;

    // Read-back values, reserved bits forced to zero.
    // Reserved bits are tied off here rather than stored, so no write can set them.
    wire [eac_pkg::DATA_W-1:0] ctrl_view = {4'h0, ready_irq_enable, master_write_arm,
                                            write_strobe, read_strobe};
    wire [eac_pkg::DATA_W-1:0] ahi_view  = {7'h00, byte_address_reg[8]};
    // Read multiplexer; the register select alone picks the view.
    wire [eac_pkg::DATA_W-1:0] rd_mux    =
        (io_sel == eac_pkg::SEL_CONTROL) ? ctrl_view :
        (io_sel == eac_pkg::SEL_DATA)    ? byte_data_reg :
        (io_sel == eac_pkg::SEL_ADDR_LO) ? byte_address_reg[7:0] : ahi_view;

    // Write timer: divides clk_sys down to the 1 MHz tick and counts the write.
    // It sees only sys_rst, so a processor reset cannot cut a write short.
    eac_write_timer #(
        .OSC_CYCLES (WRITE_OSC_CYCLES)
    ) u_timer (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .tmr     (tmr.timer)
    );

    // Interrupt enable bit; plain software storage.
    // Every control write rewrites it, so software keeps the bit set in each
    // arm and strobe write if it wants the ready interrupt.
    always_ff @(posedge clk_sys) begin
        if (sys_rst || cpu_rst) begin
            ready_irq_enable <= 1'b0;
        end else if (wr_ctrl) begin
            ready_irq_enable <= io_wdata[eac_pkg::BIT_IRQ_ENABLE];
        end
    end

    // Arm bit: set by software, cleared by hardware after four cycles.
    // An interrupt between arming and strobing therefore loses the write.
    // The window counts from the arming write itself, so a strobe is taken
    // on any of the four following edges and on none after them.
    always_ff @(posedge clk_sys) begin
        if (sys_rst || cpu_rst) begin
            master_write_arm <= 1'b0;
            arm_cnt          <= 2'h0;
        end else if (set_arm) begin
            master_write_arm <= 1'b1;
            arm_cnt          <= eac_pkg::ARM_CYCLES_M1;
        end else if (master_write_arm) begin
            arm_cnt          <= arm_cnt - 2'h1;
            master_write_arm <= (arm_cnt != 2'h0);
        end
    end

    // Write strobe: held high for the whole write, cleared at completion.
    // Processor reset leaves it alone so a running write keeps its status.
    // Writing zero to the strobe bit never clears it; only the timer can.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            write_strobe <= 1'b0;
        end else if (write_start) begin
            write_strobe <= 1'b1;
        end else if (tmr.done) begin
            write_strobe <= 1'b0;
        end
    end

    // Operands latched at start; the commit uses these, not the live registers.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wr_addr <= eac_pkg::ADDR_RESET;
            wr_data <= eac_pkg::DATA_RESET;
        end else if (write_start) begin
            wr_addr <= byte_address_reg;
            wr_data <= byte_data_reg;
        end
    end

    // Commit the byte when the timed write ends; not reset, survives cpu_rst.
    // Nothing here reads the live registers, so software may load the next
    // data byte while the current one is still being programmed.
    always_ff @(posedge clk_sys) begin
        if (tmr.done) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read strobe reads back high for one cycle after an accepted read.
    // The bit is informative only; software never needs to clear it.
    always_ff @(posedge clk_sys) begin
        if (sys_rst || cpu_rst) begin
            read_strobe <= 1'b0;
        end else begin
            read_strobe <= read_start;
        end
    end

    // Address register; frozen while a write is in progress.
    // Writes to either half are dropped, not delayed, while a write runs;
    // the latched operands already hold the address being programmed.
    always_ff @(posedge clk_sys) begin
        if (sys_rst || cpu_rst) begin
            byte_address_reg <= eac_pkg::ADDR_RESET;
        end else if (wr_alo && addr_open) begin
            byte_address_reg[7:0] <= io_wdata;
        end else if (wr_ahi && addr_open) begin
            byte_address_reg[8] <= io_wdata[0];
        end
    end

    // Data register: software writes it, a read loads the addressed byte.
    // A read takes priority over a same-cycle software write; they cannot
    // both arrive in one I/O access anyway.
    // Software may reload it mid-write; the byte programmed is the latched copy.
    always_ff @(posedge clk_sys) begin
        if (sys_rst || cpu_rst) begin
            byte_data_reg <= eac_pkg::DATA_RESET;
        end else if (read_start) begin
            byte_data_reg <= mem[byte_address_reg];
        end else if (wr_data_s) begin
            byte_data_reg <= io_wdata;
        end
    end

    // Stall counter: two cycles for a write start, four for a read.
    // Loading rather than adding keeps each stall length exact even when a
    // new start arrives while an older stall is still draining.
    // A write start wins over a read start taken in the same control write.
    always_ff @(posedge clk_sys) begin
        if (sys_rst || cpu_rst) begin
            stall_cnt <= 3'h0;
        end else if (write_start) begin
            stall_cnt <= eac_pkg::WRITE_STALL;
        end else if (read_start) begin
            stall_cnt <= eac_pkg::READ_STALL;
        end else if (stall_cnt != 3'h0) begin
            stall_cnt <= stall_cnt - 3'h1;
        end
    end

    // Registered read data, one cycle after the read strobe.
    // Only an I/O read updates it, so the value stands until the next read.
    // Processor reset leaves it alone; power-on reset alone clears it.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            io_rdata <= eac_pkg::DATA_RESET;
        end else if (io_rd) begin
            io_rdata <= rd_mux;
        end
    end

endmodule : eac_top

// file: hdl/eac_write_timer.sv
// Purpose: Times one EEPROM write with a 1 MHz tick derived from clk_sys.
// Assumes: Only sys_rst can stop it; processor reset never reaches here.
// Notes:   The tick divider free-runs only while a write is busy, to save power.
module eac_write_timer #(
    parameter logic [eac_pkg::WRITE_CNT_W-1:0] OSC_CYCLES = 14'(eac_pkg::WRITE_OSC_CYCLES)
) (
    input  wire logic   clk_sys,
    input  wire logic   sys_rst,
    eac_timer_if.timer  tmr
);

    eac_pkg::eac_wt_state_t                 state;      // Timer state.
    eac_pkg::eac_wt_state_t                 next_state; // Next timer state.
    logic [eac_pkg::DIV_W-1:0]              div_cnt;    // Clock-to-oscillator divider.
    logic [eac_pkg::WRITE_CNT_W-1:0]        osc_cnt;    // Oscillator ticks elapsed.
    logic                                   osc_tick;   // One-cycle 1 MHz enable.
    logic                                   last_tick;  // Final tick of the write.

    localparam logic [eac_pkg::DIV_W-1:0] DIV_LAST = 7'(eac_pkg::OSC_DIV - 1);

    assign osc_tick  = (state == eac_pkg::WT_RUN) && (div_cnt == DIV_LAST);
    assign last_tick = osc_tick && (osc_cnt == OSC_CYCLES - 14'h0001);
    assign tmr.busy  = (state == eac_pkg::WT_RUN);
    assign tmr.done  = last_tick;

    // Start only from idle; the run ends on the last oscillator tick.
    always_comb begin
        next_state = state;
        unique case (state)
            eac_pkg::WT_IDLE: begin
                if (tmr.start) begin
                    next_state = eac_pkg::WT_RUN;
                end
            end
            eac_pkg::WT_RUN: begin
                if (last_tick) begin
                    next_state = eac_pkg::WT_IDLE;
                end
            end
        endcase
    end

    // State and counters; both counters restart from zero on each start.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state   <= eac_pkg::WT_IDLE;
            div_cnt <= '0;
            osc_cnt <= '0;
        end else begin
            state   <= next_state;
            div_cnt <= (state != eac_pkg::WT_RUN || osc_tick) ? '0 : div_cnt + 7'h01;
            osc_cnt <= (state != eac_pkg::WT_RUN || last_tick) ? '0 :
                       osc_cnt + {13'h0000, osc_tick};
        end
    end

endmodule : eac_write_timer

// file: include/eac_pkg.sv
// Purpose: Shared constants and types for the data EEPROM access control block.
// Assumes: One 100 MHz clock; registers reached through a small I/O select port.
// Notes:   Offsets below are the select codes of the I/O register port.
package eac_pkg;

    // Register select codes on the I/O port.
    localparam logic [1:0] SEL_CONTROL = 2'h0;
    localparam logic [1:0] SEL_DATA    = 2'h1;
    localparam logic [1:0] SEL_ADDR_LO = 2'h2;
    localparam logic [1:0] SEL_ADDR_HI = 2'h3;

    // Field positions in the access control register.
    localparam int BIT_READ_STROBE  = 0;
    localparam int BIT_WRITE_STROBE = 1;
    localparam int BIT_ARM          = 2;
    localparam int BIT_IRQ_ENABLE   = 3;

    // Geometry of the byte array.
    localparam int ADDR_W     = 9;
    localparam int DATA_W     = 8;
    localparam int MEM_BYTES  = 512;

    // Values after reset.
    localparam logic [ADDR_W-1:0] ADDR_RESET = 9'h000;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

    // Clock rates and the derived oscillator divider.
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int OSC_FREQ_HZ = 1_000_000;
    localparam int OSC_DIV     = CLK_FREQ_HZ / OSC_FREQ_HZ;
    localparam int DIV_W       = 7;

    // Write duration in oscillator cycles.
    localparam int WRITE_OSC_CYCLES = 8448;
    localparam int WRITE_CNT_W      = 14;

    // Arm window and stall lengths in clock cycles.
    localparam logic [1:0] ARM_CYCLES_M1 = 2'h3;
    localparam logic [2:0] WRITE_STALL   = 3'h2;
    localparam logic [2:0] READ_STALL    = 3'h4;

    // Write timer states, Gray coded.
    typedef enum logic [1:0] {
        WT_IDLE = 2'b00,
        WT_RUN  = 2'b01
    } eac_wt_state_t;

endpackage : eac_pkg

// file: include/eac_timer_if.sv
// Purpose: Carries the start, busy and done signals to the write timer.
// Assumes: All signals live in the clk_sys domain.
// Notes:   The controller owns start; the timer owns busy and done.
interface eac_timer_if;
    logic start;  // One-cycle request to begin a timed write.
    logic busy;   // High while the timed write runs.
    logic done;   // One-cycle pulse when the write time has elapsed.

    modport ctrl  (output start, input  busy, input  done);
    modport timer (input  start, output busy, output done);
endinterface : eac_timer_if
